/* File: hw/cap2_regs_cfg.svh */
// offsets, field positions, reset values and timing counts of the cap2 bank
`ifndef CAP2_REGS_CFG_SVH
`define CAP2_REGS_CFG_SVH

`define OFF_DEV_CAP2       12'h0e4
`define OFF_DEV_CTL2       12'h0e8
`define OFF_LINK_CAP2      12'h0ec
`define OFF_LINK_CTL2      12'h0f0
`define OFF_SLOT_CAP2      12'h0f4
`define OFF_SLOT_CTL2      12'h0f8

`define BIT_LTR_SUP        11
`define BIT_FC_LTR         12
`define BIT_OBFF_SUP_LO    18
`define BIT_LTR_EN         10
`define BIT_OBFF_EN_LO     13
`define BIT_SPEED_LO       0
`define BIT_ENTER_COMPL    4
`define BIT_AUTO_DIS       5
`define BIT_SEL_DEEMPH     6
`define BIT_MARGIN_LO      7
`define BIT_MOD_COMPL      10
`define BIT_SKIP_SETS      11
`define BIT_COMPL_DEEMPH   12
`define BIT_CUR_DEEMPH     16

`define RST_LTR_SUP        1'b1
`define RST_FC_LTR         1'b0
`define RST_OBFF_SUP       2'h0
`define RST_LTR_EN         1'b0
`define RST_OBFF_EN        2'h0
`define RST_TGT_SPEED      4'h2
`define RST_DEEMPH_UP      1'b0
`define RST_DEEMPH_DN      1'b1

`define SYNC_STAGES        2'h2

`endif

/* File: hw/cap2_regs_pkg.sv */
// types shared by the cap2 register bank
package cap2_regs_pkg;

  typedef enum logic [1:0] {
    INIT_WAIT = 2'b00,
    INIT_LOAD = 2'b01,
    RUN       = 2'b10
  } init_state_t;

  typedef logic [31:0] word_t;

endpackage

/* File: hw/pin_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate

endmodule

/* File: hw/pcie_cap2_config_regs.sv */
// second-generation capability register bank of one switch port, AHB-Lite
//
// Functional notes
// - capability word bit 11 reads one, read-only
// - capability bit 12 read-only, zero, preloadable
// - capability bits 19:18 read-only, zero, preloadable
// - control bits 10 and 14:13 writable, reset zero
// - link control bit 6 read-only, port-type reset
// - link status bit 16 resets by port type
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cap2_regs_cfg.svh"
module pcie_cap2_config_regs (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire cap2_regs_pkg::word_t       hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output cap2_regs_pkg::word_t            hrdata,
  output logic                            hresp,
  // port strap and sideband preload pins
  input  wire logic                       port_is_downstream,
  input  wire logic                       preload_strobe,
  input  wire logic                       preload_fc_ltr,
  input  wire logic [1:0]                 preload_obff_sup,
  input  wire logic                       preload_select_deemph,
  // link state pins
  input  wire logic                       link_trained,
  input  wire logic                       link_deemph_level,
  // control outputs to the port logic
  output logic                            ltr_enable,
  output logic [1:0]                      obff_enable,
  output logic [3:0]                      target_link_speed,
  output logic                            enter_compliance,
  output logic                            autonomous_speed_change_disable,
  output logic [2:0]                      transmit_margin,
  output logic                            enter_modified_compliance,
  output logic                            compliance_skip_sets,
  output logic                            compliance_deemph,
  output logic                            select_deemph,
  output logic                            current_deemph
);

  import cap2_regs_pkg::*;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                           input logic [1:0] low);
    case (size)
      3'h0:    lane_mask = 4'h1 << low;
      3'h1:    lane_mask = low[1] ? 4'hc : 4'h3;
      default: lane_mask = 4'hf;
    endcase
  endfunction

  function automatic word_t merge(input word_t old, input word_t wd,
                                  input logic [3:0] lanes);
    word_t m;
    m = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction

  // synchronised pins
  logic [7:0]  pins_s;
  logic        strap_s;
  logic        pre_strobe_s;
  logic        pre_fc_ltr_s;
  logic [1:0]  pre_obff_s;
  logic        pre_deemph_s;
  logic        trained_s;
  logic        level_s;

  pin_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({link_deemph_level, link_trained, preload_select_deemph,
                preload_obff_sup, preload_fc_ltr, preload_strobe,
                port_is_downstream}),
    .sync_out (pins_s)
  );

  assign strap_s      = pins_s[0];
  assign pre_strobe_s = pins_s[1];
  assign pre_fc_ltr_s = pins_s[2];
  assign pre_obff_s   = pins_s[4:3];
  assign pre_deemph_s = pins_s[5];
  assign trained_s    = pins_s[6];
  assign level_s      = pins_s[7];

  // bus data phase state
  logic        dp_active_r;
  logic        dp_write_r;
  logic [11:0] dp_addr_r;
  logic [3:0]  dp_lanes_r;
  logic        hreadyout_r;
  word_t       hrdata_r;
  logic        hresp_r;

  // register fields
  logic        cap_fc_ltr_r;
  logic [1:0]  cap_obff_r;
  logic        ltr_en_r;
  logic [1:0]  obff_en_r;
  logic [3:0]  tgt_speed_r;
  logic        enter_compl_r;
  logic        auto_dis_r;
  logic [2:0]  tx_margin_r;
  logic        mod_compl_r;
  logic        skip_sets_r;
  logic        compl_deemph_r;
  logic        select_deemph_r;
  logic        current_deemph_r;
  logic        is_down_r;

  // init sequencer and preload edge
  init_state_t st_r;
  init_state_t st_nxt;
  logic [1:0]  init_cnt_r;
  logic        pre_strobe_d_r;

  // decode
  logic        addr_take;
  logic        wr_en;
  logic        wr_devctl;
  logic        wr_lnkctl;
  logic        pre_rise;
  word_t       dev_cap_word;
  word_t       dev_ctl_word;
  word_t       lnk_word;
  word_t       rd_word;
  word_t       wr_word;

  assign addr_take = hsel & htrans[1] & hready;
  assign wr_en     = dp_active_r & dp_write_r;
  assign wr_devctl = wr_en & (dp_addr_r == `OFF_DEV_CTL2);
  assign wr_lnkctl = wr_en & (dp_addr_r == `OFF_LINK_CTL2);
  assign pre_rise  = pre_strobe_s & ~pre_strobe_d_r & (st_r == RUN);

  assign dev_cap_word = {12'h000, cap_obff_r, 5'h00, cap_fc_ltr_r,
                         `RST_LTR_SUP, 11'h000};
  assign dev_ctl_word = {16'h0000, 1'b0, obff_en_r, 2'h0,
                         ltr_en_r, 10'h000};
  assign lnk_word     = {15'h0000, current_deemph_r, 3'h0,
                         compl_deemph_r, skip_sets_r, mod_compl_r,
                         tx_margin_r, select_deemph_r, auto_dis_r,
                         enter_compl_r, tgt_speed_r};

  // capability, status and slot words not listed read as zero
  assign rd_word =
    (dp_addr_r == `OFF_DEV_CAP2)  ? dev_cap_word :
    (dp_addr_r == `OFF_DEV_CTL2)  ? dev_ctl_word :
    (dp_addr_r == `OFF_LINK_CTL2) ? lnk_word     : 32'h0000_0000;

  assign wr_word = merge(rd_word, hwdata, dp_lanes_r);

  // one wait state per transfer so read data leaves a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_active_r <= 1'b0;
      dp_write_r  <= 1'b0;
      dp_addr_r   <= 12'h000;
      dp_lanes_r  <= 4'h0;
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h0000_0000;
      hresp_r     <= 1'b0;
    end else if (addr_take) begin
      dp_active_r <= 1'b1;
      dp_write_r  <= hwrite;
      dp_addr_r   <= {haddr[11:2], 2'b00};
      dp_lanes_r  <= lane_mask(hsize, haddr[1:0]);
      hreadyout_r <= 1'b0;
    end else if (dp_active_r) begin
      dp_active_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r    <= dp_write_r ? 32'h0000_0000 : rd_word;
    end
  end

  // strap is taken once the synchroniser holds it
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      INIT_WAIT: begin
        if (init_cnt_r == `SYNC_STAGES) begin
          st_nxt = INIT_LOAD;
        end
      end
      INIT_LOAD: st_nxt = RUN;
      RUN:       st_nxt = RUN;
      default:   st_nxt = INIT_WAIT;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r           <= INIT_WAIT;
      init_cnt_r     <= 2'h0;
      pre_strobe_d_r <= 1'b0;
    end else begin
      st_r           <= st_nxt;
      pre_strobe_d_r <= pre_strobe_s;
      if (st_r == INIT_WAIT) begin
        init_cnt_r <= init_cnt_r + 2'h1;
      end
    end
  end

  // capability defaults, overridable by sideband preload
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_fc_ltr_r <= `RST_FC_LTR;
      cap_obff_r   <= `RST_OBFF_SUP;
    end else if (pre_rise) begin
      cap_fc_ltr_r <= pre_fc_ltr_s;
      cap_obff_r   <= pre_obff_s;
    end
  end

  // device control 2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ltr_en_r  <= `RST_LTR_EN;
      obff_en_r <= `RST_OBFF_EN;
    end else if (wr_devctl) begin
      ltr_en_r  <= wr_word[`BIT_LTR_EN];
      obff_en_r <= wr_word[`BIT_OBFF_EN_LO+1:`BIT_OBFF_EN_LO];
    end
  end

  // link control 2 writable fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_speed_r    <= `RST_TGT_SPEED;
      enter_compl_r  <= 1'b0;
      auto_dis_r     <= 1'b0;
      tx_margin_r    <= 3'h0;
      mod_compl_r    <= 1'b0;
      skip_sets_r    <= 1'b0;
      compl_deemph_r <= 1'b0;
    end else if (wr_lnkctl) begin
      tgt_speed_r    <= wr_word[`BIT_SPEED_LO+3:`BIT_SPEED_LO];
      enter_compl_r  <= wr_word[`BIT_ENTER_COMPL];
      auto_dis_r     <= wr_word[`BIT_AUTO_DIS];
      tx_margin_r    <= wr_word[`BIT_MARGIN_LO+2:`BIT_MARGIN_LO];
      mod_compl_r    <= wr_word[`BIT_MOD_COMPL];
      skip_sets_r    <= wr_word[`BIT_SKIP_SETS];
      compl_deemph_r <= wr_word[`BIT_COMPL_DEEMPH];
    end
  end

  // de-emphasis select and current level by port type
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      is_down_r        <= 1'b0;
      select_deemph_r  <= `RST_DEEMPH_UP;
      current_deemph_r <= `RST_DEEMPH_UP;
    end else if (st_r == INIT_LOAD) begin
      is_down_r        <= strap_s;
      select_deemph_r  <= strap_s ? `RST_DEEMPH_DN : `RST_DEEMPH_UP;
      current_deemph_r <= strap_s ? `RST_DEEMPH_DN : `RST_DEEMPH_UP;
    end else if (st_r == RUN) begin
      if (pre_rise && is_down_r) begin
        select_deemph_r <= pre_deemph_s;
      end
      if (trained_s) begin
        current_deemph_r <= level_s;
      end
    end
  end

  assign hreadyout   = hreadyout_r;
  assign hrdata      = hrdata_r;
  assign hresp       = hresp_r;
  assign ltr_enable  = ltr_en_r;
  assign obff_enable = obff_en_r;
  assign target_link_speed               = tgt_speed_r;
  assign enter_compliance                = enter_compl_r;
  assign autonomous_speed_change_disable = auto_dis_r;
  assign transmit_margin                 = tx_margin_r;
  assign enter_modified_compliance       = mod_compl_r;
  assign compliance_skip_sets            = skip_sets_r;
  assign compliance_deemph               = compl_deemph_r;
  assign select_deemph                   = select_deemph_r;
  assign current_deemph                  = current_deemph_r;

  a_bus_wait_state: assert property ( // bus
    addr_take |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take exactly one wait state");

  a_ltr_sup_one: assert property (
    (dp_active_r && !dp_write_r && dp_addr_r == `OFF_DEV_CAP2)
      |=> hreadyout && hrdata[`BIT_LTR_SUP])
    else $error("ltr supported bit did not read one");

  a_fc_ltr_ro: assert property (
    (wr_en && dp_addr_r == `OFF_DEV_CAP2 && !pre_rise)
      |=> $stable(cap_fc_ltr_r) && $stable(cap_obff_r))
    else $error("write changed a read-only capability bit");

  a_obff_sup_read: assert property (
    (dp_active_r && !dp_write_r && dp_addr_r == `OFF_DEV_CAP2)
      |=> hrdata[`BIT_OBFF_SUP_LO+1:`BIT_OBFF_SUP_LO] == $past(cap_obff_r)
          && hrdata[`BIT_FC_LTR] == $past(cap_fc_ltr_r))
    else $error("obff supported field read wrong");

  a_dev_ctl_write: assert property (
    (wr_devctl && dp_lanes_r[1])
      |=> ltr_enable == $past(hwdata[`BIT_LTR_EN])
          && obff_enable == $past(hwdata[14:13]))
    else $error("device control write not stored");

  a_sel_deemph_ro: assert property (
    (wr_lnkctl && !pre_rise && st_r == RUN) |=> $stable(select_deemph))
    else $error("write changed de-emphasis select");

  a_deemph_strap: assert property (
    (st_r == INIT_LOAD)
      |=> select_deemph == $past(strap_s)
          && current_deemph == $past(strap_s))
    else $error("de-emphasis not set by port type");

  a_speed_write: assert property (
    (wr_lnkctl && dp_lanes_r[0])
      |=> target_link_speed == $past(hwdata[3:0]) && hreadyout)
    else $error("target link speed write not stored");

  a_cur_deemph_track: assert property (
    (st_r == RUN && trained_s) |=> current_deemph == $past(level_s))
    else $error("current de-emphasis did not follow the link level");

  a_resp_okay: assert property ( // bus
    hreadyout |-> !hresp)
    else $error("slave answered with an error response");

endmodule

/* File: testbench/pcie_cap2_config_regs_tb_top.sv */
// self-checking bench for the cap2 register bank
`timescale 1ns/1ps
`include "cap2_regs_cfg.svh"
module pcie_cap2_config_regs_tb_top;
  import cap2_regs_pkg::*;

  logic        hclk                  = 1'b0;
  logic        hresetn               = 1'b0;
  logic        hsel                  = 1'b0;
  logic [31:0] haddr                 = 32'h0;
  logic [1:0]  htrans                = 2'h0;
  logic        hwrite                = 1'b0;
  logic [2:0]  hsize                 = 3'h2;
  word_t       hwdata                = 32'h0;
  logic        port_is_downstream    = 1'b0;
  logic        preload_strobe        = 1'b0;
  logic        preload_fc_ltr        = 1'b0;
  logic [1:0]  preload_obff_sup      = 2'h0;
  logic        preload_select_deemph = 1'b0;
  logic        link_trained          = 1'b0;
  logic        link_deemph_level     = 1'b0;
  logic        hreadyout;
  word_t       hrdata;
  logic        hresp;
  logic        ltr_enable;
  logic [1:0]  obff_enable;
  logic [3:0]  target_link_speed;
  logic        enter_compliance;
  logic        autonomous_speed_change_disable;
  logic [2:0]  transmit_margin;
  logic        enter_modified_compliance;
  logic        compliance_skip_sets;
  logic        compliance_deemph;
  logic        select_deemph;
  logic        current_deemph;
  wire logic        hready;
  wire logic [12:0] lc_pins;
  wire logic [2:0]  dc_pins;
  int          mismatches  = 0;
  int          check_count = 0;

  assign hready  = hreadyout;
  // pins laid out as link control 2 bits 12:0
  assign lc_pins = {compliance_deemph, compliance_skip_sets,
                    enter_modified_compliance, transmit_margin,
                    select_deemph, autonomous_speed_change_disable,
                    enter_compliance, target_link_speed};
  assign dc_pins = {obff_enable, ltr_enable};

  always #20 hclk = ~hclk;

  pcie_cap2_config_regs i_dut (
    .hclk                            (hclk),
    .hresetn                         (hresetn),
    .hsel                            (hsel),
    .haddr                           (haddr),
    .htrans                          (htrans),
    .hwrite                          (hwrite),
    .hsize                           (hsize),
    .hwdata                          (hwdata),
    .hready                          (hready),
    .hreadyout                       (hreadyout),
    .hrdata                          (hrdata),
    .hresp                           (hresp),
    .port_is_downstream              (port_is_downstream),
    .preload_strobe                  (preload_strobe),
    .preload_fc_ltr                  (preload_fc_ltr),
    .preload_obff_sup                (preload_obff_sup),
    .preload_select_deemph           (preload_select_deemph),
    .link_trained                    (link_trained),
    .link_deemph_level               (link_deemph_level),
    .ltr_enable                      (ltr_enable),
    .obff_enable                     (obff_enable),
    .target_link_speed               (target_link_speed),
    .enter_compliance                (enter_compliance),
    .autonomous_speed_change_disable (autonomous_speed_change_disable),
    .transmit_margin                 (transmit_margin),
    .enter_modified_compliance       (enter_modified_compliance),
    .compliance_skip_sets            (compliance_skip_sets),
    .compliance_deemph               (compliance_deemph),
    .select_deemph                   (select_deemph),
    .current_deemph                  (current_deemph)
  );

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input word_t got, input word_t exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // hready and hrdata are taken at the rising edge itself
  task automatic wait_ready(output word_t rd);
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, hready, 1'b1);
    end
    rd = hrdata;
  endtask

  // one single word transfer, entered right after a rising edge
  task automatic xfer(input logic [11:0] a, input logic w, input word_t wd,
                      output word_t rd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_ready(rd);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready(rd);
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input word_t d);
    word_t t;
    xfer(a, 1'b1, d, t);
  endtask

  task automatic rd_chk(input logic [11:0] a, input word_t exp);
    word_t t;
    xfer(a, 1'b0, 32'h0, t);
    check(t, exp);
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // let the strap load and the init sequence reach run
    repeat (6) @(posedge hclk);
  endtask

  task automatic preload(input logic fc, input logic [1:0] ob, input logic sd);
    preload_fc_ltr        <= fc;
    preload_obff_sup      <= ob;
    preload_select_deemph <= sd;
    repeat (2) @(posedge hclk);
    preload_strobe <= 1'b1;
    repeat (6) @(posedge hclk);
    preload_strobe <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic test_reset_values;
    rd_chk(`OFF_DEV_CAP2, 32'h00000800);
    rd_chk(`OFF_DEV_CTL2, 32'h0);
    rd_chk(`OFF_LINK_CAP2, 32'h0);
    rd_chk(`OFF_LINK_CTL2, 32'h00000002);
    rd_chk(`OFF_SLOT_CAP2, 32'h0);
    rd_chk(`OFF_SLOT_CTL2, 32'h0);
    rd_chk(12'h0fc, 32'h0);
    check({19'h0, lc_pins}, 32'h2);
    check({29'h0, dc_pins}, 32'h0);
    $display("test reset_values done");
  endtask

  task automatic test_write_access;
    logic [11:0] ro_offs [3];
    ro_offs = '{`OFF_LINK_CAP2, `OFF_SLOT_CAP2, `OFF_SLOT_CTL2};
    wr(`OFF_DEV_CAP2, 32'hffffffff);
    rd_chk(`OFF_DEV_CAP2, 32'h00000800);
    for (int i = 0; i < 3; i++) begin
      wr(ro_offs[i], 32'hffffffff);
      rd_chk(ro_offs[i], 32'h0);
    end
    wr(`OFF_DEV_CTL2, 32'hffffffff);
    rd_chk(`OFF_DEV_CTL2, 32'h00006400);
    check({29'h0, dc_pins}, 32'h7);
    wr(`OFF_DEV_CTL2, 32'h00002000);
    rd_chk(`OFF_DEV_CTL2, 32'h00002000);
    check({29'h0, dc_pins}, 32'h2);
    wr(`OFF_LINK_CTL2, 32'hffffffff);
    rd_chk(`OFF_LINK_CTL2, 32'h00001fbf);
    check({19'h0, lc_pins}, 32'h1fbf);
    wr(`OFF_LINK_CTL2, 32'h00000a55);
    rd_chk(`OFF_LINK_CTL2, 32'h00000a15);
    check({19'h0, lc_pins}, 32'ha15);
    wr(`OFF_LINK_CTL2, 32'h00000002);
    $display("test write_access done");
  endtask

  task automatic test_preload_up;
    // select preload is dropped on the upstream port
    preload(1'b1, 2'b11, 1'b1);
    rd_chk(`OFF_DEV_CAP2, 32'h000c1800);
    rd_chk(`OFF_LINK_CTL2, 32'h00000002);
    $display("test preload_up done");
  endtask

  task automatic test_downstream;
    port_is_downstream <= 1'b1;
    do_reset();
    rd_chk(`OFF_DEV_CAP2, 32'h00000800);
    rd_chk(`OFF_LINK_CTL2, 32'h00010042);
    check({30'h0, select_deemph, current_deemph}, 32'h3);
    wr(`OFF_LINK_CTL2, 32'h00010000);
    rd_chk(`OFF_LINK_CTL2, 32'h00010040);
    wr(`OFF_LINK_CTL2, 32'h00000002);
    preload(1'b0, 2'b01, 1'b0);
    rd_chk(`OFF_DEV_CAP2, 32'h00040800);
    rd_chk(`OFF_LINK_CTL2, 32'h00010002);
    $display("test downstream done");
  endtask

  task automatic test_link_level;
    link_deemph_level <= 1'b0;
    link_trained      <= 1'b1;
    repeat (6) @(posedge hclk);
    rd_chk(`OFF_LINK_CTL2, 32'h00000002);
    link_deemph_level <= 1'b1;
    repeat (6) @(posedge hclk);
    rd_chk(`OFF_LINK_CTL2, 32'h00010002);
    check({31'h0, current_deemph}, 32'h1);
    $display("test link_level done");
  endtask

  initial begin
    do_reset();
    test_reset_values();
    test_write_access();
    test_preload_up();
    test_downstream();
    test_link_level();
    results();
  end

  // the whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    mismatches++;
    results();
  end
endmodule
